/* File: aif_irq_flags.sv */
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "aif_defines.svh"

// How it works
// R1 - Enabled overrun on any of the twelve channel results raises overrun request.
// R2 - Sequence global overrun also raises it when that sequence's mode is 0.
// R3 - Overrun enable is enable bit 2, resets 0, blocks overrun request.
// R4 - Two-bit threshold select per channel at bits 2n+4:2n+3, reset zero.
// R5 - Software keeps reserved bits zero; those bits read here as zero.
// R6 - Channel threshold flag sets on selected outside or crossing event.
// R7 - Writing one clears a threshold flag; zero leaves it; reset zero.
// R8 - Flag bits 12..23 mirror channel result overrun status.
// R9 - Flag bit 24 mirrors sequence A global result overrun.
// R10 - Flag register gathers four request flags, overrun and threshold flags.
// R11 - Sequence B overrun mirror sits at bit 25; bits 27:26 reserved.
// R12 - Threshold request flag is the OR of the twelve channel flags.
// R13 - Overrun request flag stays set until all contributing overruns clear.
// R14 - Channel events raise requests whatever sequence or trigger caused them.
// R15 - Each request is a level: flag and enable both set; the threshold request has no enable and follows its flag alone.
module aif_irq_flags #(
  parameter int NCH = 12
) (
  input  wire logic                   mclk_in,
  input  wire logic                   nrst_in,
  input  wire logic [`AIF_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]            wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [31:0]            rdata_out,
  input  wire logic [NCH-1:0]         chan_overrun_in,
  input  wire logic [NCH-1:0]         thr_outside_in,
  input  wire logic [NCH-1:0]         thr_crossing_in,
  input  wire logic                   seq_a_overrun_in,
  input  wire logic                   seq_b_overrun_in,
  input  wire logic                   seq_a_mode_in,
  input  wire logic                   seq_b_mode_in,
  input  wire logic                   seq_a_int_flag_in,
  input  wire logic                   seq_b_int_flag_in,
  output logic                        seq_a_irq_enable_out,
  output logic                        seq_b_irq_enable_out,
  output logic                        overrun_irq_out,
  output logic                        threshold_irq_out,
  output logic                        seq_a_irq_out,
  output logic                        seq_b_irq_out,
  output logic                        irq_out
);
  initial begin
    if (NCH != 12) $error("aif_irq_flags: layout fixed at 12 channels");
  end

  localparam int SEL_W = 2 * NCH;

  // Configuration and mirror state
  logic [SEL_W-1:0]      sel_ff;
  logic                  ovr_en_ff;
  logic                  seqa_en_ff;
  logic                  seqb_en_ff;
  logic [`AIF_ST_W-1:0]  mask_ff;
  logic [NCH-1:0]        chan_ovr_ff;
  logic                  seq_a_overrun_mirror_ff;
  logic                  seq_b_overrun_mirror_ff;
  logic                  seqa_mode_ff;
  logic                  seqb_mode_ff;
  logic                  seqa_int_ff;
  logic                  seqb_int_ff;
  logic [31:0]           rdata_ff;
  logic                  ovr_irq_ff;
  logic                  thr_irq_ff;
  logic                  seqa_irq_ff;
  logic                  seqb_irq_ff;

  // Decode
  wire hit_en    = (addr_in == `AIF_OFS_ENABLE);
  wire hit_flags = (addr_in == `AIF_OFS_FLAGS);
  wire hit_mask  = (addr_in == `AIF_OFS_MASK);
  wire hit_stat  = (addr_in == `AIF_OFS_STATUS);
  wire wr_en     = wr_in & hit_en;
  wire wr_flags  = wr_in & hit_flags;
  wire wr_mask   = wr_in & hit_mask;
  wire wr_stat   = wr_in & hit_stat;

  wire [NCH-1:0] thr_clear = wr_flags ?
    wdata_in[`AIF_FL_THR_LSB +: NCH] : '0; // R7

  // Channel threshold flags
  logic [NCH-1:0] thr_flag;
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    aif_thr_chan u_thr (
      .mclk_in     (mclk_in),
      .nrst_in     (nrst_in),
      .sel_in      (sel_ff[2*ch +: 2]), // R4
      .outside_in  (thr_outside_in[ch]), // R14
      .crossing_in (thr_crossing_in[ch]),
      .clear_in    (thr_clear[ch]),
      .flag_out    (thr_flag[ch])
    );
  end

  // Request flags
  wire thr_int_flag = |thr_flag; // R12
  // Global overruns count only in per-conversion mode
  wire seq_a_overrun_mirror_hit = seq_a_overrun_mirror_ff &
                      (seqa_mode_ff == `AIF_SEQ_MODE_CONV); // R2
  wire seq_b_overrun_mirror_hit = seq_b_overrun_mirror_ff &
                      (seqb_mode_ff == `AIF_SEQ_MODE_CONV); // R2
  wire overrun_irq_flag_flag = (|chan_ovr_ff) | seq_a_overrun_mirror_hit | seq_b_overrun_mirror_hit; // R1 R13

  wire nxt_ovr_irq  = overrun_irq_flag_flag & ovr_en_ff; // R3 R15
  wire nxt_thr_irq  = thr_int_flag; // R15
  wire nxt_seqa_irq = seqa_int_ff & seqa_en_ff; // R15
  wire nxt_seqb_irq = seqb_int_ff & seqb_en_ff; // R15

  // Flag register image
  logic [31:0] flags_img;
  always_comb begin
    flags_img = `AIF_ZERO32; // R5
    flags_img[`AIF_FL_THR_LSB +: NCH] = thr_flag; // R10
    flags_img[`AIF_FL_OVR_LSB +: NCH] = chan_ovr_ff; // R8
    flags_img[`AIF_FL_SEQ_A_OVERRUN_MIRROR_BIT]   = seq_a_overrun_mirror_ff; // R9
    flags_img[`AIF_FL_SEQ_B_OVERRUN_MIRROR_BIT]   = seq_b_overrun_mirror_ff; // R11
    flags_img[`AIF_FL_SEQA_INT_BIT]   = seqa_int_ff;
    flags_img[`AIF_FL_SEQB_INT_BIT]   = seqb_int_ff;
    flags_img[`AIF_FL_THR_INT_BIT]    = thr_int_flag; // R12
    flags_img[`AIF_FL_OVERRUN_IRQ_FLAG_BIT]    = overrun_irq_flag_flag; // R13
  end

  logic [31:0] en_img;
  always_comb begin
    en_img = `AIF_ZERO32; // R5
    en_img[`AIF_EN_SEQA_BIT] = seqa_en_ff;
    en_img[`AIF_EN_SEQB_BIT] = seqb_en_ff;
    en_img[`AIF_EN_OVR_BIT]  = ovr_en_ff;
    en_img[`AIF_EN_SEL_LSB +: SEL_W] = sel_ff;
  end

  // Sticky status and mask
  wire [`AIF_ST_W-1:0] st_events = {nxt_seqb_irq & ~seqb_irq_ff,
                                    nxt_seqa_irq & ~seqa_irq_ff,
                                    nxt_ovr_irq & ~ovr_irq_ff,
                                    nxt_thr_irq & ~thr_irq_ff};
  wire [`AIF_ST_W-1:0] st_clear = wr_stat ? wdata_in[`AIF_ST_W-1:0] : '0;
  logic [`AIF_ST_W-1:0] st_bits;

  aif_sticky #(
    .W (`AIF_ST_W)
  ) u_sticky (
    .mclk_in    (mclk_in),
    .nrst_in    (nrst_in),
    .event_in   (st_events),
    .clear_in   (st_clear),
    .mask_in    (mask_ff),
    .status_out (st_bits),
    .irq_out    (irq_out)
  );

  wire [31:0] st_img   = {{(32-`AIF_ST_W){1'b0}}, st_bits};
  wire [31:0] mask_img = {{(32-`AIF_ST_W){1'b0}}, mask_ff};

  // Unmapped reads return zero
  wire [31:0] rd_mux = hit_en    ? en_img    :
                       hit_flags ? flags_img :
                       hit_mask  ? mask_img  :
                       hit_stat  ? st_img    : `AIF_ZERO32;
  wire [31:0] nxt_rdata = rd_in ? rd_mux : `AIF_ZERO32;

  // Configuration registers
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sel_ff     <= '0; // R4
      ovr_en_ff  <= 1'b0; // R3
      seqa_en_ff <= 1'b0;
      seqb_en_ff <= 1'b0;
      mask_ff    <= '0;
    end else begin
      if (wr_en) begin
        sel_ff     <= wdata_in[`AIF_EN_SEL_LSB +: SEL_W]; // R4
        ovr_en_ff  <= wdata_in[`AIF_EN_OVR_BIT]; // R3
        seqa_en_ff <= wdata_in[`AIF_EN_SEQA_BIT];
        seqb_en_ff <= wdata_in[`AIF_EN_SEQB_BIT];
      end
      if (wr_mask) begin
        mask_ff <= wdata_in[`AIF_ST_W-1:0];
      end
    end
  end

  // Mirrors of result-register status, one cycle behind
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      chan_ovr_ff  <= '0; // R8
      seq_a_overrun_mirror_ff  <= 1'b0;
      seq_b_overrun_mirror_ff  <= 1'b0;
      seqa_mode_ff <= 1'b0;
      seqb_mode_ff <= 1'b0;
      seqa_int_ff  <= 1'b0;
      seqb_int_ff  <= 1'b0;
    end else begin
      chan_ovr_ff  <= chan_overrun_in; // R8
      seq_a_overrun_mirror_ff  <= seq_a_overrun_in; // R9
      seq_b_overrun_mirror_ff  <= seq_b_overrun_in; // R11
      seqa_mode_ff <= seq_a_mode_in;
      seqb_mode_ff <= seq_b_mode_in;
      seqa_int_ff  <= seq_a_int_flag_in;
      seqb_int_ff  <= seq_b_int_flag_in;
    end
  end

  // Request levels and read data
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ovr_irq_ff  <= 1'b0;
      thr_irq_ff  <= 1'b0;
      seqa_irq_ff <= 1'b0;
      seqb_irq_ff <= 1'b0;
      rdata_ff    <= `AIF_ZERO32;
    end else begin
      ovr_irq_ff  <= nxt_ovr_irq; // R1 R15
      thr_irq_ff  <= nxt_thr_irq; // R12
      seqa_irq_ff <= nxt_seqa_irq;
      seqb_irq_ff <= nxt_seqb_irq;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign rdata_out            = rdata_ff;
  assign overrun_irq_out      = ovr_irq_ff;
  assign threshold_irq_out    = thr_irq_ff;
  assign seq_a_irq_out        = seqa_irq_ff;
  assign seq_b_irq_out        = seqb_irq_ff;
  assign seq_a_irq_enable_out = seqa_en_ff;
  assign seq_b_irq_enable_out = seqb_en_ff;
endmodule

/* File: aif_defines.svh */
`ifndef AIF_DEFINES_SVH
`define AIF_DEFINES_SVH

// Register map; printed offsets are word aligned byte addresses
`define AIF_ADDR_W            32
`define AIF_OFS_ENABLE        32'h4001C064
`define AIF_OFS_FLAGS         32'h4001C068
`define AIF_OFS_MASK          32'h4001C0F0
`define AIF_OFS_STATUS        32'h4001C0F4

// Enable register fields
`define AIF_EN_SEQA_BIT       0
`define AIF_EN_SEQB_BIT       1
`define AIF_EN_OVR_BIT        2
`define AIF_EN_SEL_LSB        3
`define AIF_EN_USED_MSB       26

// Flag register fields
`define AIF_FL_THR_LSB        0
`define AIF_FL_OVR_LSB        12
`define AIF_FL_SEQ_A_OVERRUN_MIRROR_BIT   24
`define AIF_FL_SEQ_B_OVERRUN_MIRROR_BIT   25
`define AIF_FL_SEQA_INT_BIT   28
`define AIF_FL_SEQB_INT_BIT   29
`define AIF_FL_THR_INT_BIT    30
`define AIF_FL_OVERRUN_IRQ_FLAG_BIT    31

// Sticky status bits
`define AIF_ST_THR_BIT        0
`define AIF_ST_OVR_BIT        1
`define AIF_ST_SEQA_BIT       2
`define AIF_ST_SEQB_BIT       3
`define AIF_ST_W              4

`define AIF_ZERO32            32'h00000000
`define AIF_SEQ_MODE_CONV     1'h0

`endif

/* File: aif_pkg.sv */
package aif_pkg;
  typedef enum logic [1:0] {
    AIF_SEL_OFF      = 2'h0,
    AIF_SEL_OUTSIDE  = 2'h1,
    AIF_SEL_CROSSING = 2'h2,
    AIF_SEL_RSVD     = 2'h3
  } aif_sel_t;
endpackage

/* File: aif_thr_chan.sv */
`timescale 1ns/10ps
`include "aif_defines.svh"

// One channel's write-one-to-clear threshold event flag
module aif_thr_chan (
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic [1:0] sel_in,
  input  wire logic       outside_in,
  input  wire logic       crossing_in,
  input  wire logic       clear_in,
  output logic            flag_out
);
  logic flag_ff;
  logic nxt_flag;
  logic hit;

  assign hit = (sel_in == aif_pkg::AIF_SEL_OUTSIDE  && outside_in) ||
               (sel_in == aif_pkg::AIF_SEL_CROSSING && crossing_in); // R6
  // Set wins over a same-cycle clear
  assign nxt_flag = hit | (flag_ff & ~clear_in); // R7

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      flag_ff <= 1'b0; // R7
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_out = flag_ff;
endmodule

/* File: aif_sticky.sv */
`timescale 1ns/10ps
`include "aif_defines.svh"

// Sticky event bits, write one to clear, masked onto one level
module aif_sticky #(
  parameter int W = 4
) (
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] event_in,
  input  wire logic [W-1:0] clear_in,
  input  wire logic [W-1:0] mask_in,
  output logic [W-1:0]      status_out,
  output logic              irq_out
);
  logic [W-1:0] st_ff;
  logic         irq_ff;
  logic [W-1:0] nxt_st;

  initial begin
    if (W < 1) $error("aif_sticky: W must be at least 1");
  end

  assign nxt_st = event_in | (st_ff & ~clear_in);

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      st_ff  <= '0;
      irq_ff <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      irq_ff <= |(nxt_st & mask_in);
    end
  end

  assign status_out = st_ff;
  assign irq_out    = irq_ff;
endmodule

/* File: aif_irq_flags_asserts.sv */
`timescale 1ns/10ps
`include "aif_defines.svh"
module aif_irq_flags_chk #(
  parameter int NCH = 12
) (
  input wire logic             mclk_in,
  input wire logic             nrst_in,
  input wire logic [31:0]      addr_in,
  input wire logic             wr_in,
  input wire logic             rd_in,
  input wire logic [31:0]      rdata_out,
  input wire logic [NCH-1:0]   chan_overrun_in,
  input wire logic [NCH-1:0]   thr_outside_in,
  input wire logic [NCH-1:0]   thr_crossing_in,
  input wire logic             seq_a_overrun_in,
  input wire logic             seq_b_overrun_in,
  input wire logic             seq_a_mode_in,
  input wire logic             seq_b_mode_in,
  input wire logic             seq_a_irq_enable_out,
  input wire logic             overrun_irq_out,
  input wire logic             threshold_irq_out,
  input wire logic             seq_a_irq_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  wire ovr_src = |chan_overrun_in | (seq_a_overrun_in & ~seq_a_mode_in)
               | (seq_b_overrun_in & ~seq_b_mode_in);
  wire thr_evt  = |(thr_outside_in | thr_crossing_in);
  wire rd_fl    = rd_in && addr_in == `AIF_OFS_FLAGS;
  wire rd_en    = rd_in && addr_in == `AIF_OFS_ENABLE;
  wire wr_fl    = wr_in && addr_in == `AIF_OFS_FLAGS;
  wire rd_map   = rd_fl || rd_en || (rd_in && (addr_in == `AIF_OFS_MASK
                  || addr_in == `AIF_OFS_STATUS));
  a_ovr_cause: assert property (
    overrun_irq_out |-> $past(ovr_src, 2))
    else $error("overrun request without a cause");
  // Enable writes may also drop the request
  a_ovr_release: assert property (
    $fell(overrun_irq_out) |-> !$past(ovr_src, 2) || $past(wr_in)
                               || $past(wr_in, 2))
    else $error("overrun request dropped early");
  a_thr_cause: assert property (
    $rose(threshold_irq_out) |-> $past(thr_evt, 2))
    else $error("threshold request without an event");
  a_thr_clear: assert property (
    $fell(threshold_irq_out) |-> $past(wr_fl, 2))
    else $error("threshold request dropped without a clear");
  a_flag_mirror: assert property (
    $past(rd_fl) |-> rdata_out[27:12] == {2'h0, $past(seq_b_overrun_in, 2),
                   $past(seq_a_overrun_in, 2), $past(chan_overrun_in, 2)})
    else $error("overrun mirror bits wrong");
  a_en_rsvd: assert property (
    $past(rd_en) |-> rdata_out[31:27] == 5'h00)
    else $error("enable reserved bits not zero");
  a_rd_quiet: assert property (
    !$past(rd_map) |-> rdata_out == 32'h00000000)
    else $error("read data outside a mapped read");
  a_seq_gate: assert property (
    seq_a_irq_out |-> seq_a_irq_enable_out || $past(seq_a_irq_enable_out))
    else $error("sequence request while disabled");
endmodule
bind aif_irq_flags aif_irq_flags_chk #(.NCH(NCH)) i_chk (
  .mclk_in              (mclk_in),
  .nrst_in              (nrst_in),
  .addr_in              (addr_in),
  .wr_in                (wr_in),
  .rd_in                (rd_in),
  .rdata_out            (rdata_out),
  .chan_overrun_in      (chan_overrun_in),
  .thr_outside_in       (thr_outside_in),
  .thr_crossing_in      (thr_crossing_in),
  .seq_a_overrun_in     (seq_a_overrun_in),
  .seq_b_overrun_in     (seq_b_overrun_in),
  .seq_a_mode_in        (seq_a_mode_in),
  .seq_b_mode_in        (seq_b_mode_in),
  .seq_a_irq_enable_out (seq_a_irq_enable_out),
  .overrun_irq_out      (overrun_irq_out),
  .threshold_irq_out    (threshold_irq_out),
  .seq_a_irq_out        (seq_a_irq_out)
);

/* File: aif_conv_model.sv */
`timescale 1ns/10ps
// Converter side; only a result read removes its overrun
module aif_conv_model (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic [11:0] ovr_set_in,
  input  wire logic [11:0] ovr_read_in,
  input  wire logic [11:0] out_req_in,
  input  wire logic [11:0] cross_req_in,
  output logic      [11:0] overrun_out,
  output logic      [11:0] outside_out,
  output logic      [11:0] crossing_out
);
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      {overrun_out, outside_out, crossing_out} <= 36'h0;
    end else begin
      overrun_out  <= (overrun_out | ovr_set_in) & ~ovr_read_in;
      outside_out  <= out_req_in;
      crossing_out <= cross_req_in;
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/10ps
`include "aif_defines.svh"
`define CHK(n, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
  end
module tb;
  localparam logic [31:0] EN = `AIF_OFS_ENABLE;
  localparam logic [31:0] FL = `AIF_OFS_FLAGS;
  localparam logic [31:0] MK = `AIF_OFS_MASK;
  localparam logic [31:0] ST = `AIF_OFS_STATUS;
  int          n_fail = 0;
  int          check_count = 0;
  logic        mclk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        rd_d = 1'b0;
  logic        b;
  logic [31:0] addr_in = 32'h0;
  logic [31:0] wdata_in = 32'h0;
  logic [31:0] rdata_out, r;
  logic [38:0] e, w;
  logic [1:0]  ac = 2'h0;
  logic [11:0] chan_overrun_in, thr_outside_in, thr_crossing_in, o;
  logic [11:0] os = 12'h0, cl = 12'h0, oq = 12'h0, cq = 12'h0;
  logic [5:0]  s, sq = 6'h0;
  logic        seq_a_overrun_in, seq_b_overrun_in, seq_a_mode_in;
  logic        seq_b_mode_in, seq_a_int_flag_in, seq_b_int_flag_in;
  logic        seq_a_irq_enable_out, seq_b_irq_enable_out, irq_out;
  logic        overrun_irq_out, threshold_irq_out;
  logic        seq_a_irq_out, seq_b_irq_out;
  logic [38:0] exp_q[$];
  // Everything software can see after a read, judged in one word
  wire  [38:0] seen = {seq_b_irq_out, seq_a_irq_out, seq_b_irq_enable_out,
                       seq_a_irq_enable_out, overrun_irq_out,
                       threshold_irq_out, irq_out, rdata_out};
  assign {seq_b_int_flag_in, seq_a_int_flag_in, seq_b_mode_in,
          seq_a_mode_in, seq_b_overrun_in, seq_a_overrun_in} = sq;
  aif_irq_flags i_dut (
    .mclk_in              (mclk_in),
    .nrst_in              (nrst_in),
    .addr_in              (addr_in),
    .wdata_in             (wdata_in),
    .wr_in                (wr_in),
    .rd_in                (rd_in),
    .rdata_out            (rdata_out),
    .chan_overrun_in      (chan_overrun_in),
    .thr_outside_in       (thr_outside_in),
    .thr_crossing_in      (thr_crossing_in),
    .seq_a_overrun_in     (seq_a_overrun_in),
    .seq_b_overrun_in     (seq_b_overrun_in),
    .seq_a_mode_in        (seq_a_mode_in),
    .seq_b_mode_in        (seq_b_mode_in),
    .seq_a_int_flag_in    (seq_a_int_flag_in),
    .seq_b_int_flag_in    (seq_b_int_flag_in),
    .seq_a_irq_enable_out (seq_a_irq_enable_out),
    .seq_b_irq_enable_out (seq_b_irq_enable_out),
    .overrun_irq_out      (overrun_irq_out),
    .threshold_irq_out    (threshold_irq_out),
    .seq_a_irq_out        (seq_a_irq_out),
    .seq_b_irq_out        (seq_b_irq_out),
    .irq_out              (irq_out)
  );
  aif_conv_model i_conv (
    .mclk_in      (mclk_in),
    .nrst_in      (nrst_in),
    .ovr_set_in   (os),
    .ovr_read_in  (cl),
    .out_req_in   (oq),
    .cross_req_in (cq),
    .overrun_out  (chan_overrun_in),
    .outside_out  (thr_outside_in),
    .crossing_out (thr_crossing_in)
  );
  always #5 mclk_in = ~mclk_in;
  // Read data and request levels are judged together in the data cycle
  always @(posedge mclk_in) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("read", e, seen)
    end
    rd_d <= rd_in;
  end
  task automatic idle(int n);
    repeat (n) @(posedge mclk_in) {wr_in, rd_in, os, cl, oq, cq} <= 50'h0;
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge mclk_in);
    {wr_in, rd_in, addr_in, wdata_in} <= {2'h2, a, d};
  endtask
  task automatic rd(logic [31:0] a, logic [38:0] x);
    @(posedge mclk_in);
    {wr_in, rd_in, addr_in} <= {2'h1, a};
    exp_q.push_back(x);
  endtask
  task automatic far(logic [11:0] st, rr, ou, cr);
    @(posedge mclk_in);
    {wr_in, rd_in, os, cl, oq, cq} <= {2'h0, st, rr, ou, cr};
    idle(4);
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hF915));
    idle(5);
    nrst_in <= 1'b1;
    idle(1);
    foreach (r[i]) if (i < 5) rd(32'h4001C064 + 32'(i * 4), 39'h0);
    rd(ST + 32'h4, 39'h0);
    r = $urandom & 32'h07FFFFF8;
    wr(EN, r);
    rd(EN, {7'h0, r});
    r = 32'h0;
    for (int n = 0; n < 12; n++) r[2*n+3 +: 2] = 2'(n % 4);
    wr(EN, r);
    wr(MK, 32'hF);
    far(12'h0, 12'h0, 12'hFFF, 12'h0);
    rd(FL, {7'h3, 32'h40000222});
    far(12'h0, 12'h0, 12'h0, 12'hFFF);
    rd(FL, {7'h3, 32'h40000666});
    wr(FL, 32'h00FFF222);
    rd(FL, {7'h3, 32'h40000444});
    wr(FL, 32'h444);
    rd(FL, {7'h1, 32'h0});
    wr(ST, 32'h1);
    wr(MK, 32'h0);
    far(12'h0, 12'h0, 12'h002, 12'h0);
    rd(ST, {7'h2, 32'h1});
    wr(MK, 32'hF);
    rd(ST, {7'h3, 32'h1});
    wr(FL, 32'h2);
    wr(ST, 32'h1);
    wr(EN, 32'h0);
    o = 12'($urandom) | 12'h001;
    far(o, 12'h0, 12'h0, 12'h0);
    rd(FL, {7'h0, 8'h80, o, 12'h0});
    // Both sequence enables on, so their requests follow their flags
    wr(EN, 32'h7);
    idle(3);
    rd(ST, {7'h1D, 32'h2});
    far(12'h0, o, 12'h0, 12'h0);
    rd(FL, {7'h19, 32'h0});
    for (int k = 0; k < 8; k++) begin
      s = 6'($urandom);
      ac = ac | s[5:4];
      idle(1);
      sq <= s;
      idle(3);
      b = (s[0] & ~s[2]) | (s[1] & ~s[3]);
      w = {s[5:4], 2'h3, b, 2'h1, b, 1'h0, s[5:4], 2'h0, s[1:0], 24'h0};
      rd(FL, w);
    end
    // First rise of each sequence request leaves its sticky bit set
    sq <= 6'h0;
    idle(4);
    rd(ST, {7'h19, 28'h0, ac, 2'h2});
    wr(ST, 32'hF);
    rd(ST, {7'h18, 32'h0});
    idle(2);
    nrst_in <= 1'b0;
    idle(3);
    nrst_in <= 1'b1;
    idle(1);
    rd(EN, 39'h0);
    rd(FL, 39'h0);
    idle(4);
    wrap_up();
  end
endmodule
